// ==== logic/stsm_pkg.sv ====
// Constants shared by the serial transmit status block.
// Assumes an 8-bit register port with a 3-bit word address.
package stsm_pkg;

	// ----------------------------------------------------------------
	// Register addresses
	// ----------------------------------------------------------------
	localparam logic [2:0] STSM_HOLD_ADDR = 3'h0;
	localparam logic [2:0] STSM_STAT_ADDR = 3'h1;
	localparam logic [2:0] STSM_MODE_ADDR = 3'h2;
	localparam logic [2:0] STSM_CMD_ADDR = 3'h3;
	localparam logic [2:0] STSM_DIV_ADDR = 3'h4;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int STSM_MODE_SYNC_BIT = 0;
	localparam int STSM_MODE_CLK_SEL_BIT = 4;
	localparam int STSM_CMD_TX_ON_BIT = 0;
	localparam int STSM_CMD_RX_ON_BIT = 2;
	localparam int STSM_CMD_RTS_BIT = 5;
	localparam int STSM_CMD_LOOP_BIT = 7;
	localparam int STSM_STAT_SPACE_BIT = 0;
	localparam int STSM_STAT_EVENT_BIT = 2;
	localparam int STSM_STAT_DRAINED_BIT = 3;
	localparam int STSM_STAT_CHANGE_BIT = 4;
	localparam int STSM_STAT_CARRIER_BIT = 6;
	localparam int STSM_STAT_SET_READY_BIT = 7;

	// ----------------------------------------------------------------
	// Reset values and frame counts
	// ----------------------------------------------------------------
	localparam logic [7:0] STSM_MODE_RST = 8'h00;
	localparam logic [7:0] STSM_CMD_RST = 8'h00;
	localparam logic [7:0] STSM_DIV_RST = 8'h00;
	localparam logic [3:0] STSM_ASYNC_LAST = 4'h9;
	localparam logic [3:0] STSM_SYNC_LAST = 4'h7;
	localparam logic [9:0] STSM_FILL = 10'h3FF;

	typedef enum logic [1:0] {
		STSM_IDLE = 2'b01,
		STSM_SHIFT = 2'b10
	} stsm_state_type;

endpackage

// ==== logic/stsm_sync.sv ====
// Two-stage synchroniser for a group of asynchronous pin levels.
// Assumes the inputs are quasi-static compared with mclk.
`timescale 1ns/1ps
module stsm_sync #(
	parameter int W = 1
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} stsm_sync_type;

	stsm_sync_type s_q;
	stsm_sync_type s_d;

	// The first stage feeds only the second stage.
	always_comb begin
		s_d.meta = async_in;
		s_d.stable = s_q.meta;
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign sync_out = s_q.stable;
endmodule // stsm_sync

// ==== logic/stsm_baud.sv ====
// Internal bit rate divider producing a one-cycle enable pulse.
// Assumes a divisor of N gives one pulse every N+1 mclk cycles.
`timescale 1ns/1ps
module stsm_baud (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [7:0] divisor,
	output logic tick
);
	typedef struct packed {
		logic [7:0] count;
		logic pulse;
	} stsm_baud_type;

	stsm_baud_type s_q;
	stsm_baud_type s_d;

	always_comb begin
		s_d = s_q;
		s_d.pulse = 1'b0;
		if (s_q.count >= divisor) begin
			s_d.count = 8'h00;
			s_d.pulse = 1'b1;
		end else begin
			s_d.count = s_q.count + 8'h01;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign tick = s_q.pulse;
endmodule // stsm_baud

// ==== logic/stsm_tx_status.sv ====
// Transmitter status and modem line change logic of a serial port.
// Assumes a host on the register port and a modem on the pins.
//
// How it works
// - Line marks as drained flag sets.
// - Carrier or set-ready change raises change flag.
// - Carrier and set-ready status bits are live.
// - Status read clears the change flag.
// - Underrun raises the drained flag.
// - Writing the holding register clears drained flag.
// - Disabled transmitter clears drained after fill sent.
// - Drained and change share pin and bit.
// - Reset clears every mode bit.
// - Cleared mode selects external bit clock.
// - Line rises only after a bit clock edge.
// - Pad bits appear before request-to-send rises.
//
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/1ps
module stsm_tx_status
	import stsm_pkg::*;
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic tx_bit_clock,
	input wire logic carrier_n,
	input wire logic set_ready_n,
	output logic txd,
	output logic rts_n,
	input wire logic tx_space_avail_i,
	output logic tx_space_avail_o,
	output logic tx_space_avail_oe_n,
	input wire logic tx_drained_flag_i,
	output logic tx_drained_flag_o,
	output logic tx_drained_flag_oe_n
);
	import stsm_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		stsm_state_type state;
		logic [9:0] shreg;
		logic [3:0] cnt;
		logic [7:0] hold;
		logic hold_full;
		logic drained;
		logic change;
		logic clk_prev;
		logic dcd_prev;
		logic dsr_prev;
		logic txd;
		logic rts_n;
		logic [7:0] mode;
		logic [7:0] cmd;
		logic [7:0] div;
		logic [7:0] rdata;
	} stsm_main_type;

	stsm_main_type s_q;
	stsm_main_type s_d;

	logic [2:0] pins_s;
	logic clk_s;
	logic dcd_s;
	logic dsr_s;
	logic baud_tick;
	logic tick;
	logic tx_on;
	logic sync_mode;
	logic underrun;
	logic space_avail;
	logic event_flag;
	logic change_set;
	logic wr_hold;
	logic rd_stat;
	logic [9:0] word;
	logic [3:0] last;

	// ----------------------------------------------------------------
	// Pin synchronisers and bit rate source
	// ----------------------------------------------------------------
	stsm_sync #(
		.W(3)
	) u_sync (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.async_in({tx_bit_clock, carrier_n, set_ready_n}),
		.sync_out(pins_s)
	);

	stsm_baud u_baud (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.divisor(s_q.div),
		.tick(baud_tick)
	);

	assign clk_s = pins_s[2];
	assign dcd_s = pins_s[1];
	assign dsr_s = pins_s[0];

	// External clock shifts on its falling edge; mode zero picks it.
	assign tick = s_q.mode[STSM_MODE_CLK_SEL_BIT] ? baud_tick :
		(s_q.clk_prev & ~clk_s);

	// ----------------------------------------------------------------
	// Shared decode
	// ----------------------------------------------------------------
	assign tx_on = s_q.cmd[STSM_CMD_TX_ON_BIT];
	assign sync_mode = s_q.mode[STSM_MODE_SYNC_BIT];
	assign wr_hold = reg_wr && (reg_addr == STSM_HOLD_ADDR);
	assign rd_stat = reg_rd && (reg_addr == STSM_STAT_ADDR);
	assign word = sync_mode ? {2'b11, s_q.hold} : {1'b1, s_q.hold, 1'b0};
	assign last = sync_mode ? STSM_SYNC_LAST : STSM_ASYNC_LAST;
	assign underrun = tick && (s_q.state == STSM_SHIFT) &&
		(s_q.cnt == 4'h0) && !s_q.hold_full;
	assign space_avail = tx_on && !s_q.hold_full;
	assign event_flag = s_q.drained | s_q.change;
	// A change is only noticed while a direction is on and not looped.
	assign change_set = ((dcd_s != s_q.dcd_prev) ||
		(dsr_s != s_q.dsr_prev)) &&
		(s_q.cmd[STSM_CMD_RX_ON_BIT] || tx_on) &&
		!s_q.cmd[STSM_CMD_LOOP_BIT];

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.clk_prev = clk_s;
		s_d.dcd_prev = dcd_s;
		s_d.dsr_prev = dsr_s;
		s_d.rdata = 8'h00;

		// Register writes come first so that hardware sets win.
		if (reg_wr) begin
			unique case (reg_addr)
				STSM_HOLD_ADDR: begin
					s_d.hold = reg_wdata;
					s_d.hold_full = 1'b1;
					s_d.drained = 1'b0;
				end
				STSM_MODE_ADDR: s_d.mode = reg_wdata;
				STSM_CMD_ADDR: s_d.cmd = reg_wdata;
				STSM_DIV_ADDR: s_d.div = reg_wdata;
				default: ;
			endcase
		end

		if (reg_rd) begin
			unique case (reg_addr)
				STSM_STAT_ADDR: begin
					s_d.rdata[STSM_STAT_SPACE_BIT] = space_avail;
					s_d.rdata[STSM_STAT_EVENT_BIT] = event_flag;
					s_d.rdata[STSM_STAT_DRAINED_BIT] = s_q.drained;
					s_d.rdata[STSM_STAT_CHANGE_BIT] = s_q.change;
					s_d.rdata[STSM_STAT_CARRIER_BIT] = ~dcd_s;
					s_d.rdata[STSM_STAT_SET_READY_BIT] = ~dsr_s;
					s_d.change = 1'b0;
				end
				STSM_MODE_ADDR: s_d.rdata = s_q.mode;
				STSM_CMD_ADDR: s_d.rdata = s_q.cmd;
				STSM_DIV_ADDR: s_d.rdata = s_q.div;
				default: s_d.rdata = 8'h00;
			endcase
		end

		if (change_set) begin
			s_d.change = 1'b1;
		end

		// The line stays at break until the first bit tick arrives.
		if (tick) begin
			unique case (s_q.state)
				STSM_IDLE: begin
					s_d.txd = 1'b1;
					if (tx_on) begin
						s_d.state = STSM_SHIFT;
						s_d.cnt = 4'h0;
					end
				end
				STSM_SHIFT: begin
					if (s_q.cnt != 4'h0) begin
						s_d.txd = s_q.shreg[0];
						s_d.shreg = {1'b1, s_q.shreg[9:1]};
						s_d.cnt = s_q.cnt - 4'h1;
					end else if (s_q.hold_full) begin
						s_d.txd = word[0];
						s_d.shreg = {1'b1, word[9:1]};
						s_d.cnt = last;
						s_d.hold_full = wr_hold;
					end else if (tx_on) begin
						// Fill is all ones, so the line marks.
						s_d.drained = 1'b1;
						s_d.txd = 1'b1;
						s_d.shreg = STSM_FILL;
						s_d.cnt = last;
					end else begin
						// Any fill has now gone out in full.
						s_d.state = STSM_IDLE;
						s_d.txd = 1'b1;
						s_d.drained = 1'b0;
					end
				end
			endcase
		end

		// Request-to-send waits until a pending pad has begun to shift.
		if (s_q.cmd[STSM_CMD_RTS_BIT]) begin
			s_d.rts_n = 1'b0;
		end else if ((s_q.state == STSM_IDLE) ||
			((s_q.cnt != 4'h0) && !s_q.hold_full)) begin
			s_d.rts_n = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			s_q.state <= STSM_IDLE;
			s_q.shreg <= STSM_FILL;
			s_q.cnt <= 4'h0;
			s_q.hold <= 8'h00;
			s_q.hold_full <= 1'b0;
			s_q.drained <= 1'b0;
			s_q.change <= 1'b0;
			s_q.clk_prev <= 1'b0;
			s_q.dcd_prev <= 1'b0;
			s_q.dsr_prev <= 1'b0;
			s_q.txd <= 1'b0;
			s_q.rts_n <= 1'b1;
			s_q.mode <= STSM_MODE_RST;
			s_q.cmd <= STSM_CMD_RST;
			s_q.div <= STSM_DIV_RST;
			s_q.rdata <= 8'h00;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Loopback keeps the modem line marking.
	assign txd = s_q.txd | s_q.cmd[STSM_CMD_LOOP_BIT];
	assign rts_n = s_q.rts_n;
	assign reg_rdata = s_q.rdata;
	// Open-drain pins are pulled low while their condition is active.
	// Each pin has its own driver, so they are never wired together.
	assign tx_space_avail_o = 1'b0;
	assign tx_space_avail_oe_n = ~space_avail;
	assign tx_drained_flag_o = 1'b0;
	assign tx_drained_flag_oe_n = ~event_flag;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (sys_rst);

	change_raise_a: assert property (
		change_set |=> s_q.change)
	else $error("Modem line change was not flagged.");

	change_clear_a: assert property (
		rd_stat && !change_set |=> !s_q.change)
	else $error("Status read did not clear the change flag.");

	live_bits_a: assert property (
		rd_stat |=> (reg_rdata[STSM_STAT_CARRIER_BIT] == $past(~dcd_s)) &&
		(reg_rdata[STSM_STAT_SET_READY_BIT] == $past(~dsr_s)))
	else $error("Carrier or set-ready bit is not live.");

	shared_bit_a: assert property (
		rd_stat |=> reg_rdata[STSM_STAT_EVENT_BIT] ==
		($past(s_q.drained) | $past(s_q.change)))
	else $error("Shared status bit is wrong.");

	underrun_set_a: assert property (
		underrun && tx_on |=> s_q.drained)
	else $error("Underrun did not raise the drained flag.");

	write_clear_a: assert property (
		wr_hold && !underrun |=> !s_q.drained)
	else $error("Holding write did not clear the drained flag.");

	marking_hold_a: assert property (
		$rose(s_q.drained) |-> s_q.txd && (s_q.shreg == STSM_FILL))
	else $error("Line is not marking after the drained flag.");

	disable_clear_a: assert property (
		$fell(s_q.drained) && !$past(wr_hold) |->
		!$past(tx_on) && (s_q.state == STSM_IDLE))
	else $error("Drained flag fell without disable and fill.");

	break_first_a: assert property (
		$rose(s_q.txd) |-> $past(tick))
	else $error("Line rose without a bit clock edge.");

	mode_reset_a: assert property (
		$past(sys_rst) |-> (s_q.mode == 8'h00) &&
		!s_q.mode[STSM_MODE_CLK_SEL_BIT])
	else $error("Mode bits not cleared by reset.");

	rts_pad_a: assert property (
		$rose(s_q.rts_n) |-> ($past(s_q.state) == STSM_IDLE) ||
		!$past(s_q.hold_full))
	else $error("Request-to-send rose before pad began.");

	ext_tick_a: assert property (
		!s_q.mode[STSM_MODE_CLK_SEL_BIT] && tick |->
		$past(clk_s) && !clk_s)
	else $error("Bit tick without a falling bit clock edge.");

	idle_quiet_a: assert property (
		s_q.state == STSM_IDLE |-> !s_q.drained)
	else $error("Drained flag set while the transmitter is idle.");

	fill_count_a: assert property (
		$rose(s_q.drained) |-> s_q.cnt == $past(last))
	else $error("Fill frame does not last a full character.");

	loop_quiet_a: assert property (
		s_q.cmd[STSM_CMD_LOOP_BIT] |=> !$rose(s_q.change))
	else $error("Change flagged during loopback.");

	change_seen_c: cover property (change_set ##1 rd_stat);
	drained_seen_c: cover property ($rose(s_q.drained) ##[1:400] wr_hold);
	disable_end_c: cover property ($fell(s_q.drained) && !tx_on);
	rts_drop_c: cover property ($rose(s_q.rts_n) && sync_mode);
	int_clock_c: cover property (s_q.mode[STSM_MODE_CLK_SEL_BIT] && tick && tx_on);
endmodule // stsm_tx_status

// ==== tb/stsm_modem.sv ====
// Modem model on the serial side: bit clock source and frame capture.
// Assumes asynchronous frames, one start, eight data LSB first, one stop.
`timescale 1ns/1ps
module stsm_modem (
	input wire logic run,
	input wire logic txd,
	output logic bit_clk,
	output logic [7:0] rx_byte,
	output logic [7:0] rx_count
);
	int cnt;
	logic [8:0] sh;

	// ----------------------------------------------------------------
	// Bit clock
	// ----------------------------------------------------------------
	// The clock stands high while run is low; the odd offset keeps its
	// falling edges away from the block's own clock edges.
	initial begin
		bit_clk = 1'b1;
		forever begin
			wait (run);
			#203 bit_clk = 1'b0;
			#197 bit_clk = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Capture
	// ----------------------------------------------------------------
	// A falling edge samples the bit launched by the previous edge.
	initial begin
		cnt = 0;
		sh = 9'h000;
		rx_byte = 8'h00;
		rx_count = 8'h00;
	end
	always @(negedge bit_clk) begin
		if (cnt == 0) begin
			if (txd === 1'b0)
				cnt = 1;
		end else begin
			sh = {txd, sh[8:1]};
			cnt = cnt + 1;
			if (cnt == 10) begin
				rx_byte = sh[7:0];
				rx_count = rx_count + 8'h01;
				cnt = 0;
			end
		end
	end
endmodule // stsm_modem

// ==== tb/stsm_tx_status_tb_top.sv ====
// Self-checking bench for the transmitter status block.
// Assumes the modem model makes the bit clock and captures frames.
`timescale 1ns/1ps
module stsm_tx_status_tb_top;
	import stsm_pkg::*;
	logic mclk, sys_rst, reg_wr, reg_rd, run, txd, rts_n;
	logic [2:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, rd_val, rx_byte, rx_count, n0;
	logic tx_bit_clock, carrier_n, set_ready_n;
	logic space_o, space_oe_n, drained_o, drained_oe_n;
	logic space_pin, drained_pin;
	int n_errors, checks, cyc, i;

	// ----------------------------------------------------------------
	// Pins and instances
	// ----------------------------------------------------------------
	// Each open-drain pin has its own pull-up, never a shared wire.
	assign space_pin = space_oe_n ? 1'b1 : space_o;
	assign drained_pin = drained_oe_n ? 1'b1 : drained_o;

	stsm_tx_status dut (
		.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .tx_bit_clock(tx_bit_clock),
		.carrier_n(carrier_n), .set_ready_n(set_ready_n), .txd(txd),
		.rts_n(rts_n), .tx_space_avail_i(space_pin),
		.tx_space_avail_o(space_o), .tx_space_avail_oe_n(space_oe_n),
		.tx_drained_flag_i(drained_pin), .tx_drained_flag_o(drained_o),
		.tx_drained_flag_oe_n(drained_oe_n)
	);
	stsm_modem modem (.run(run), .txd(txd), .bit_clk(tx_bit_clock),
		.rx_byte(rx_byte), .rx_count(rx_count));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			n_errors = n_errors + 1;
			$display("mismatch at %0t: timeout", $time);
			finish_test();
		end
	end
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp,
		input string what);
		checks = checks + 1;
		if (got !== exp) begin
			n_errors = n_errors + 1;
			$display("mismatch at %0t: %s %h not %h", $time, what, got, exp);
		end
	endtask
	task automatic cmp1(input logic got, input logic exp, input string what);
		cmp8({7'h00, got}, {7'h00, exp}, what);
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 rd_val = reg_rdata;
	endtask
	task automatic wait_drained(input logic exp, input int max);
		for (i = 0; i < max && drained_pin !== exp; i++)
			@(posedge mclk);
		cmp1(drained_pin, exp, "drained pin");
	endtask
	task automatic finish_test();
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		rd(STSM_MODE_ADDR);
		cmp8(rd_val, 8'h00, "mode");
		rd(STSM_STAT_ADDR);
		cmp8(rd_val, 8'h00, "status");
		rd(3'h5);
		cmp8(rd_val, 8'h00, "unmapped");
		repeat (100) @(posedge mclk);
		cmp1(txd, 1'b0, "break");
		cmp1(rts_n, 1'b1, "rts idle");
		cmp1(rts_n | txd, 1'b1, "modem data idle");
		run <= 1'b1;
		repeat (100) @(posedge mclk);
		cmp1(txd, 1'b1, "mark");
	endtask
	task automatic t_tx();
		wr(STSM_CMD_ADDR, 8'h21);
		repeat (2) @(posedge mclk);
		cmp1(rts_n, 1'b0, "rts on");
		wait_drained(1'b0, 60);
		rd(STSM_STAT_ADDR);
		cmp8(rd_val, 8'h0D, "drained status");
		repeat (12) @(posedge mclk);
		cmp1(txd, 1'b1, "mark after drained");
		n0 = rx_count;
		wr(STSM_HOLD_ADDR, 8'hA5);
		repeat (2) @(posedge mclk);
		cmp1(drained_pin, 1'b1, "drained cleared");
		for (i = 0; i < 300 && rx_count == n0; i++)
			@(posedge mclk);
		cmp8(rx_byte, 8'hA5, "frame");
		wait_drained(1'b0, 200);
		wr(STSM_CMD_ADDR, 8'h01);
		for (i = 0; i < 200 && rts_n !== 1'b1; i++)
			@(posedge mclk);
		cmp1(rts_n, 1'b1, "rts off");
		wr(STSM_CMD_ADDR, 8'h00);
		wait_drained(1'b1, 200);
		cmp1(space_pin, 1'b1, "space off");
		run <= 1'b0;
	endtask
	task automatic t_change();
		wr(STSM_CMD_ADDR, 8'h04);
		carrier_n <= 1'b0;
		repeat (6) @(posedge mclk);
		cmp1(drained_pin, 1'b0, "change pin");
		rd(STSM_STAT_ADDR);
		cmp8(rd_val, 8'h54, "change status");
		rd(STSM_STAT_ADDR);
		cmp8(rd_val, 8'h40, "change cleared");
		wr(STSM_CMD_ADDR, 8'h84);
		set_ready_n <= 1'b0;
		repeat (6) @(posedge mclk);
		rd(STSM_STAT_ADDR);
		cmp8(rd_val, 8'hC0, "loopback status");
		cmp1(txd, 1'b1, "loopback mark");
		@(posedge mclk);
		carrier_n <= 1'b1;
		set_ready_n <= 1'b1;
		repeat (6) @(posedge mclk);
		wr(STSM_CMD_ADDR, 8'h00);
		rd(STSM_STAT_ADDR);
		cmp8(rd_val, 8'h00, "live idle");
	endtask
	task automatic t_sync();
		wr(STSM_MODE_ADDR, 8'h11);
		wr(STSM_DIV_ADDR, 8'h07);
		rd(STSM_MODE_ADDR);
		cmp8(rd_val, 8'h11, "mode sync");
		wr(STSM_CMD_ADDR, 8'h21);
		wr(STSM_HOLD_ADDR, 8'h3C);
		repeat (2) @(posedge mclk);
		for (i = 0; i < 100 && space_pin !== 1'b0; i++)
			@(posedge mclk);
		cmp1(space_pin, 1'b0, "sync space");
		wr(STSM_HOLD_ADDR, 8'hFF);
		wr(STSM_CMD_ADDR, 8'h20);
		wr(STSM_CMD_ADDR, 8'h00);
		repeat (4) @(posedge mclk);
		cmp1(rts_n, 1'b0, "rts held for pad");
		for (i = 0; i < 100 && rts_n !== 1'b1; i++)
			@(posedge mclk);
		cmp1(rts_n, 1'b1, "rts off after pad");
		cmp1(txd, 1'b1, "pad on line");
		repeat (80) @(posedge mclk);
		cmp1(drained_pin, 1'b1, "sync drained off");
		cmp1(space_pin, 1'b1, "sync space off");
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		sys_rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 3'h0;
		reg_wdata = 8'h00;
		run = 1'b0;
		carrier_n = 1'b1;
		set_ready_n = 1'b1;
		n_errors = 0;
		checks = 0;
		cyc = 0;
		repeat (16) @(posedge mclk);
		sys_rst <= 1'b0;
		t_reset();
		t_tx();
		t_change();
		t_sync();
		finish_test();
	end
endmodule // stsm_tx_status_tb_top
